// >>> design/clk_path_pkg.sv
// Package with register offsets, field positions and reset values for the clock path block
package clk_path_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OUTPUT_FEATURE_CONTROL_OFS = 8'h01;
  localparam logic [ADDR_W-1:0] PLL_CLOCK_PATH_CONFIG_OFS = 8'h02;
  // output_feature_control fields
  localparam int RAMP_OUT_EN_BIT = 13;
  localparam int SYNC_OUT_EN_BIT = 11;
  localparam int SYNC_INVERT_BIT = 10;
  localparam logic [DATA_W-1:0] OFC_WRITE_MASK = 32'h0000_2c00;
  localparam logic [DATA_W-1:0] OFC_RESET = 32'h0000_0800;
  // pll_clock_path_config fields
  localparam int DIV_RESET_BIT = 22;
  localparam int DIV_SEL_HI = 21;
  localparam int DIV_SEL_LO = 20;
  localparam int DOUBLER_EN_BIT = 19;
  localparam int PLL_EN_BIT = 18;
  localparam int DIV_EN_BIT = 17;
  localparam int DOUBLER_EDGE_BIT = 16;
  localparam int FB_N_HI = 15;
  localparam int FB_N_LO = 8;
  localparam logic [DATA_W-1:0] PCC_WRITE_MASK = 32'h007f_ff00;
  localparam logic [DATA_W-1:0] PCC_RESET = 32'h0000_1900;
  localparam logic [7:0] FB_N_MIN = 8'h0a;
  localparam logic [7:0] FB_N_DEFAULT = 8'h19;
  localparam int DIV_CNT_W = 3;
endpackage : clk_path_pkg

// >>> design/ref_divider.sv
// Reference clock divider by 1, 2, 4 or 8 with synchronous restart
`timescale 1ns/100ps
module ref_divider #(
  parameter int CNT_W = clk_path_pkg::DIV_CNT_W
) (
  input wire logic core_clk_i, // System clock
  input wire logic nrst_i, // Synchronous reset, active low
  input wire logic ref_tick_i, // One pulse per reference clock edge
  input wire logic restart_i, // Restart the divider phase
  input wire logic [1:0] sel_i, // Ratio code
  output logic tick_o // Divided reference tick
);
  import clk_path_pkg::*;

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [CNT_W-1:0] last;

  always_comb begin
    last = CNT_W'((1 << sel_i) - 1);
    next_cnt = cnt;
    tick_o = 1'b0;
    if (restart_i) begin
      next_cnt = '0;
    end else if (ref_tick_i) begin
      if (cnt >= last) begin
        next_cnt = '0;
        tick_o = 1'b1;
      end else begin
        next_cnt = cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end
endmodule : ref_divider

// >>> design/clock_path_and_sync_config.sv
// Clock path and sync output configuration registers with their output controls
`timescale 1ns/100ps
module clock_path_and_sync_config (
  input wire logic core_clk_i, // 40 MHz system clock
  input wire logic nrst_i, // Synchronous reset, active low
  input wire logic wr_en_i, // Register write strobe
  input wire logic [clk_path_pkg::ADDR_W-1:0] addr_i, // Register offset
  input wire logic [clk_path_pkg::DATA_W-1:0] wdata_i, // Write data
  output logic [clk_path_pkg::DATA_W-1:0] rdata_o, // Read data, registered
  input wire logic ref_tick_i, // Reference clock edge pulse
  input wire logic sync_clk_int_i, // Internal sync clock level
  input wire logic ramp_limit_i, // Internal ramp-limit-reached level
  output logic ramp_limit_reached_pin_o, // Ramp-limit pin output
  output logic ramp_limit_reached_pin_oe_o, // Ramp-limit pin output enable
  output logic sync_clk_pin_o, // Sync clock pin
  output logic pll_ref_tick_o, // Reference tick after divider
  output logic doubler_on_o, // Doubler circuit active
  output logic pll_enable_o, // PLL powered
  output logic sysclk_from_pll_o, // System clock taken from PLL
  output logic [7:0] pll_mult_n_o, // Feedback N in use
  output logic fb_n_invalid_o // Programmed N below valid range
);
  import clk_path_pkg::*;

  // Configuration words as software sees them
  logic [DATA_W-1:0] ofc;
  logic [DATA_W-1:0] pcc;
  logic [DATA_W-1:0] next_ofc;
  logic [DATA_W-1:0] next_pcc;
  logic ofc_hit;
  logic pcc_hit;
  // Read path
  logic [DATA_W-1:0] next_rdata;
  // Divider control taken from the clock path word
  logic div_restart;
  logic div_tick;
  logic [1:0] div_sel;
  logic div_enable;
  logic [7:0] fb_n;
  // Next values of the registered outputs
  logic next_ref_tick;
  logic next_ramp;
  logic next_ramp_oe;
  logic next_sync;
  logic next_doubler;
  logic next_pll_en;
  logic next_sysclk_pll;
  logic [7:0] next_mult_n;
  logic next_n_invalid;

  // Only writable bits survive a write; open and reserved bits read back zero
  function automatic logic [DATA_W-1:0] masked_write(input logic [DATA_W-1:0] d,
                                                     input logic [DATA_W-1:0] m);
    masked_write = d & m;
  endfunction : masked_write

  // Address decode shared by the write and read paths
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] ofs);
    reg_hit = (a == ofs);
  endfunction : reg_hit

  always_comb begin
    ofc_hit = reg_hit(addr_i, OUTPUT_FEATURE_CONTROL_OFS);
    pcc_hit = reg_hit(addr_i, PLL_CLOCK_PATH_CONFIG_OFS);
  end

  // Register file; the reset bit is a strobe and never stays set
  always_comb begin
    next_ofc = ofc;
    next_pcc = pcc;
    next_pcc[DIV_RESET_BIT] = 1'b0;
    div_restart = 1'b0;
    if (wr_en_i && ofc_hit) begin
      next_ofc = masked_write(wdata_i, OFC_WRITE_MASK);
    end else if (wr_en_i && pcc_hit) begin
      next_pcc = masked_write(wdata_i, PCC_WRITE_MASK);
      next_pcc[DIV_RESET_BIT] = 1'b0;
      div_restart = wdata_i[DIV_RESET_BIT];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      ofc <= OFC_RESET;
      pcc <= PCC_RESET;
    end else begin
      ofc <= next_ofc;
      pcc <= next_pcc;
    end
  end

  // Read data follows the address one edge later
  always_comb begin
    if (ofc_hit) begin
      next_rdata = ofc;
    end else if (pcc_hit) begin
      next_rdata = pcc;
    end else begin
      next_rdata = '0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= next_rdata;
    end
  end

  assign div_sel = pcc[DIV_SEL_HI:DIV_SEL_LO];
  assign div_enable = pcc[DIV_EN_BIT];
  assign fb_n = pcc[FB_N_HI:FB_N_LO];

  ref_divider #(
    .CNT_W(DIV_CNT_W)
  ) u_ref_divider (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .ref_tick_i(ref_tick_i),
    .restart_i(div_restart),
    .sel_i(div_sel),
    .tick_o(div_tick)
  );

  // Bypass also goes through a flop, so both paths have the same latency
  always_comb begin
    next_ref_tick = div_enable ? div_tick : ref_tick_i;
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      pll_ref_tick_o <= 1'b0;
    end else begin
      pll_ref_tick_o <= next_ref_tick;
    end
  end

  // Ramp-limit pin; enable low leaves the pin undriven
  always_comb begin
    next_ramp_oe = ofc[RAMP_OUT_EN_BIT];
    next_ramp = ofc[RAMP_OUT_EN_BIT] & ramp_limit_i;
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      ramp_limit_reached_pin_o <= 1'b0;
      ramp_limit_reached_pin_oe_o <= 1'b0;
    end else begin
      ramp_limit_reached_pin_o <= next_ramp;
      ramp_limit_reached_pin_oe_o <= next_ramp_oe;
    end
  end

  // Internal sync clock keeps running; only the pin is gated
  always_comb begin
    next_sync = ofc[SYNC_OUT_EN_BIT] & (sync_clk_int_i ^ ofc[SYNC_INVERT_BIT]);
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      sync_clk_pin_o <= 1'b0;
    end else begin
      sync_clk_pin_o <= next_sync;
    end
  end

  // Doubler needs both of its bits
  always_comb begin
    next_doubler = pcc[DOUBLER_EN_BIT] & pcc[DOUBLER_EDGE_BIT];
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      doubler_on_o <= 1'b0;
    end else begin
      doubler_on_o <= next_doubler;
    end
  end

  // PLL power and system clock source move together
  always_comb begin
    next_pll_en = pcc[PLL_EN_BIT];
    next_sysclk_pll = pcc[PLL_EN_BIT];
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      pll_enable_o <= 1'b0;
      sysclk_from_pll_o <= 1'b0;
    end else begin
      pll_enable_o <= next_pll_en;
      sysclk_from_pll_o <= next_sysclk_pll;
    end
  end

  // Out-of-range N is kept as written but flagged, so software can see it
  always_comb begin
    next_mult_n = fb_n;
    next_n_invalid = fb_n < FB_N_MIN;
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      pll_mult_n_o <= FB_N_DEFAULT;
      fb_n_invalid_o <= 1'b0;
    end else begin
      pll_mult_n_o <= next_mult_n;
      fb_n_invalid_o <= next_n_invalid;
    end
  end
endmodule : clock_path_and_sync_config

// >>> bench/clk_path_monitor.sv
// Port checker for the clock path block
`timescale 1ns/100ps
module clk_path_monitor (
  input logic core_clk_i, nrst_i, wr_en_i, ref_tick_i, sync_clk_int_i, ramp_limit_i,
  input logic [7:0] addr_i, pll_mult_n_o,
  input logic [31:0] wdata_i,
  input logic ramp_limit_reached_pin_o, ramp_limit_reached_pin_oe_o, sync_clk_pin_o,
  input logic pll_ref_tick_o, doubler_on_o, pll_enable_o, sysclk_from_pll_o, fb_n_invalid_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  // Register lands at the write edge, outputs one edge later
  property w2(a, c, ok);
    wr_en_i && addr_i == a && c |-> ##2 ok;
  endproperty
  ramp_pin_a: assert property (ramp_limit_reached_pin_o ==
    (ramp_limit_reached_pin_oe_o & $past(ramp_limit_i))) else $error("ramp pin");
  sync_off_a: assert property (w2(8'h01, !wdata_i[11], !sync_clk_pin_o))
    else $error("sync not low");
  sync_pol_a: assert property (w2(8'h01, wdata_i[11],
    sync_clk_pin_o == ($past(sync_clk_int_i) ^ $past(wdata_i[10], 2)))) else $error("sync pol");
  div_off_a: assert property (w2(8'h02, !wdata_i[17],
    pll_ref_tick_o == $past(ref_tick_i))) else $error("divider bypass");
  doubler_a: assert property (w2(8'h02, 1'b1,
    doubler_on_o == ($past(wdata_i[19], 2) & $past(wdata_i[16], 2)))) else $error("doubler");
  pll_sel_a: assert property (w2(8'h02, 1'b1, pll_enable_o == $past(wdata_i[18], 2)
    && sysclk_from_pll_o == pll_enable_o)) else $error("pll select");
  fb_n_a: assert property (w2(8'h02, 1'b1, pll_mult_n_o == $past(wdata_i[15:8], 2)))
    else $error("feedback n");
  n_range_a: assert property (fb_n_invalid_o == (pll_mult_n_o < 8'h0a))
    else $error("n range flag");
  cover property (pll_ref_tick_o);
  cover property (doubler_on_o);
  cover property (ramp_limit_reached_pin_o);
endmodule : clk_path_monitor
bind clock_path_and_sync_config clk_path_monitor mon_u (.*);

// >>> bench/ref_src_model.sv
// Reference clock source and internal sync clock stand-in
`timescale 1ns/100ps
module ref_src_model #(parameter int GAP = 3) (
  input wire logic core_clk_i, // System clock
  output logic ref_tick_o, // One pulse every GAP cycles, larger GAP is a slower source
  output logic sync_o // Internal sync clock
);
  int cnt = 0;
  initial ref_tick_o = 0;
  initial sync_o = 0;
  always @(posedge core_clk_i) begin
    cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
    ref_tick_o <= (cnt == GAP - 1);
    sync_o <= ~sync_o;
  end
endmodule : ref_src_model

// >>> bench/clock_path_and_sync_config_tb.sv
// Self-checking bench for the clock path and sync configuration block
`timescale 1ns/100ps
module clock_path_and_sync_config_tb;
  logic core_clk_i = 0, nrst_i = 0, wr_en_i = 0, ramp_limit_i = 0, s;
  logic [7:0] addr_i = 8'h00, pll_mult_n_o, n;
  logic [31:0] wdata_i = 32'h0, rdata_o;
  logic ref_tick_i, sync_clk_int_i, ramp_limit_reached_pin_o, ramp_limit_reached_pin_oe_o;
  logic sync_clk_pin_o, pll_ref_tick_o, doubler_on_o, pll_enable_o, sysclk_from_pll_o;
  logic fb_n_invalid_o;
  int errors = 0, checks_done = 0, vco_cal_starts = 0;
  clock_path_and_sync_config dut_u (.*);
  ref_src_model src_u (.core_clk_i, .ref_tick_o(ref_tick_i), .sync_o(sync_clk_int_i));
  task final_report;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  task ck(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : ck
  task step;
    @(posedge core_clk_i) #1;
  endtask : step
  task wr(input logic [7:0] a, input logic [31:0] d);
    if (a == 8'h02 && d[18]) vco_cal_starts++;
    @(posedge core_clk_i) wr_en_i <= 1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge core_clk_i) wr_en_i <= 0;
    step;
    step;
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk_i) addr_i <= a;
    step;
    ck(rdata_o, e);
  endtask : rd
  // Cycles between two divided ticks; waits are bounded so a dead divider fails
  task gap(input int e);
    int c;
    c = 0;
    while (pll_ref_tick_o !== 1'b1 && c < 99) begin
      step;
      c++;
    end
    c = 0;
    do begin
      step;
      c++;
    end while (pll_ref_tick_o !== 1'b1 && c < 99);
    ck(c, e);
  endtask : gap
  initial forever #12.5 core_clk_i = ~core_clk_i;
  initial begin
    repeat (20000) @(posedge core_clk_i);
    errors++;
    final_report;
  end
  initial begin
    repeat (10) @(posedge core_clk_i);
    nrst_i <= 1;
    rd(8'h01, 32'h0000_0800);
    rd(8'h02, 32'h0000_1900);
    rd(8'h05, 32'h0);
    wr(8'h01, 32'hffff_ffff);
    rd(8'h01, 32'h0000_2c00);
    wr(8'h02, 32'hffff_ffff);
    rd(8'h02, 32'h003f_ff00);
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk_i) ramp_limit_i <= i[0];
      wr(8'h01, {18'h0, i[1], 13'h0});
      ck(ramp_limit_reached_pin_oe_o, i[1]);
      ck(ramp_limit_reached_pin_o, i[1] & i[0]);
      wr(8'h01, {20'h0, i[1], i[0], 10'h0});
      @(negedge core_clk_i) s = sync_clk_int_i;
      step;
      ck(sync_clk_pin_o, i[1] & (s ^ i[0]));
    end
    for (int i = 0; i < 8; i++) begin
      n = 8'h09 + i[7:0];
      wr(8'h02, {12'h0, i[2], i[1], 1'b0, i[0], n, 8'h0});
      ck(doubler_on_o, i[2] & i[0]);
      ck({pll_enable_o, sysclk_from_pll_o}, {2{i[1]}});
      ck({fb_n_invalid_o, pll_mult_n_o}, {i == 0, n});
    end
    ck(vco_cal_starts, 5);
    for (int k = 0; k < 4; k++) begin
      wr(8'h02, {9'h0, 1'b1, k[1:0], 4'b0010, 16'h1900});
      gap(3 << k);
    end
    wr(8'h02, 32'h0030_1900);
    gap(3);
    final_report;
  end
endmodule : clock_path_and_sync_config_tb
